// ---- rtl/rsl_top.sv ----
// Rate selection latch, auto-rate stepping and AHB-Lite register slave
//
// Register access over AHB-Lite and the register addresses were decided locally.
`include "rsl_map.svh"

module rsl_top #(
   parameter int ARS_CYCLES = `RSL_ARS_CYCLES
) (
   input wire logic clock, // System clock, 10 MHz
   input wire logic rst_n, // Async reset, active low
   input wire logic clk_en, // Freezes all state when low
   input wire logic hsel, // AHB slave select
   input wire logic [31:0] haddr, // AHB address
   input wire logic [1:0] htrans, // AHB transfer type
   input wire logic hwrite, // AHB write
   input wire logic [2:0] hsize, // AHB size
   input wire logic [31:0] hwdata, // AHB write data
   input wire logic hready, // AHB bus ready
   output logic [31:0] hrdata, // AHB read data
   output logic hreadyout, // AHB slave ready
   output logic hresp, // AHB response, always OKAY
   input wire logic auto_select, // High selects automatic rate mode
   input wire logic rate_write_strobe, // Manual latch strobe
   input wire logic rate_index_bit0_i, // Index bit 0 pin level
   input wire logic rate_index_bit1_i, // Index bit 1 pin level
   output logic rate_index_bit0_o, // Index bit 0 drive value
   output logic rate_index_bit1_o, // Index bit 1 drive value
   output logic rate_index_oe_n, // Index bus drive enable, low drives
   input wire logic carrier_detect_flag, // Carrier present
   input wire logic frequency_detector, // Frequency detector active
   input wire logic harmonic_lock_flag, // Harmonic lock seen
   output logic rate_search_request, // Rate mismatch, search wanted
   output logic [1:0] rate_sel, // Selected rate configuration
   output logic irq // Level interrupt
);

   logic [6:0] pins_s;
   logic auto_s;
   logic strobe_s;
   logic [1:0] idx_s;
   logic carrier_s;
   logic freq_s;
   logic hl_s;
   logic addr_ok;
   logic [2:0] ev;
   rsl_pkg::rsl_state_t st_q;
   rsl_pkg::rsl_state_t st_d;

   rsl_sync #(
      .W(7)
   ) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .din({auto_select, rate_write_strobe, rate_index_bit1_i, rate_index_bit0_i,
            carrier_detect_flag, frequency_detector, harmonic_lock_flag}),
      .dout(pins_s)
   );

   assign auto_s = pins_s[6];
   assign strobe_s = pins_s[5];
   assign idx_s = pins_s[4:3];
   assign carrier_s = pins_s[2];
   assign freq_s = pins_s[1];
   assign hl_s = pins_s[0];

   function automatic logic [31:0] status_word(input rsl_pkg::rsl_state_t s, input logic manual,
                                               input logic strobe);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`RSL_ST_SEL_HI:`RSL_ST_SEL_LO] = s.sel;
      w[`RSL_ST_SEARCH] = s.search;
      w[`RSL_ST_MANUAL] = manual;
      w[`RSL_ST_STROBE] = strobe;
      return w;
   endfunction

   assign addr_ok = hsel && htrans[1] && hready;

   always_comb begin
      st_d = st_q;
      ev = 3'h0;
      st_d.hreadyout = 1'b1;
      st_d.search = carrier_s && (freq_s || hl_s);
      if (!auto_s) begin
         st_d.ars_cnt = 32'h0000_0000;
         if (strobe_s) begin
            st_d.sel = idx_s;
         end
      end else if (st_q.search && st_q.ars_en) begin
         if (st_q.ars_cnt == 32'(ARS_CYCLES - 1)) begin
            st_d.ars_cnt = 32'h0000_0000;
            st_d.sel = 2'(st_q.sel + 2'h1);
         end else begin
            st_d.ars_cnt = st_q.ars_cnt + 32'h0000_0001;
         end
      end else begin
         st_d.ars_cnt = 32'h0000_0000;
      end
      st_d.idx_oe_n = !auto_s;
      st_d.idx_out = st_d.sel;
      ev[`RSL_EV_SEL_CHANGE] = st_d.sel != st_q.sel;
      ev[`RSL_EV_SEARCH_RISE] = st_d.search && !st_q.search;
      ev[`RSL_EV_SEARCH_FALL] = !st_d.search && st_q.search;
      if (st_q.phase == rsl_pkg::RSL_PH_WRITE) begin
         case (st_q.wr_idx)
            `RSL_OFF_CTRL: begin
               st_d.ars_en = hwdata[`RSL_CTRL_ARS_EN];
            end
            `RSL_OFF_IRQ_MASK: begin
               st_d.irq_mask = hwdata[`RSL_EV_W-1:0];
            end
            default: begin
            end
         endcase
      end
      st_d.phase = rsl_pkg::RSL_PH_IDLE;
      st_d.hrdata = 32'h0000_0000;
      if (addr_ok && hwrite) begin
         st_d.phase = rsl_pkg::RSL_PH_WRITE;
         st_d.wr_idx = haddr[7:2];
      end else if (addr_ok) begin
         case (haddr[7:2])
            `RSL_OFF_CTRL: begin
               st_d.hrdata = {31'h0000_0000, st_q.ars_en};
            end
            `RSL_OFF_STATUS: begin
               st_d.hrdata = status_word(st_q, !auto_s, strobe_s);
            end
            `RSL_OFF_IRQ_STAT: begin
               st_d.hrdata = {29'h0000_0000, st_q.irq_stat};
               st_d.irq_stat = 3'h0;
            end
            `RSL_OFF_IRQ_MASK: begin
               st_d.hrdata = {29'h0000_0000, st_q.irq_mask};
            end
            default: begin
            end
         endcase
      end
      st_d.irq_stat = st_d.irq_stat | ev;
      st_d.irq = |(st_d.irq_stat & st_d.irq_mask);
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
         st_q.phase <= rsl_pkg::RSL_PH_IDLE;
         st_q.ars_en <= 1'b1;
         st_q.irq_mask <= `RSL_IRQ_MASK_RST;
         st_q.idx_oe_n <= 1'b1;
         st_q.hreadyout <= 1'b1;
      end else if (clk_en) begin
         st_q <= st_d;
      end
   end

   assign hrdata = st_q.hrdata;
   assign hreadyout = st_q.hreadyout;
   assign hresp = 1'b0;
   assign rate_index_bit0_o = st_q.idx_out[0];
   assign rate_index_bit1_o = st_q.idx_out[1];
   assign rate_index_oe_n = st_q.idx_oe_n;
   assign rate_search_request = st_q.search;
   assign rate_sel = st_q.sel;
   assign irq = st_q.irq;

   default clocking cb @(posedge clock iff clk_en);
   endclocking
   default disable iff (!rst_n);

   AST_MANUAL_RELEASE: assert property (!auto_s |=> rate_index_oe_n)
      else $error("Index bus driven in manual mode");
   AST_LATCH_LOAD: assert property (!auto_s && strobe_s |=> rate_sel == $past(idx_s))
      else $error("Strobe did not load index bus");
   AST_LATCH_HOLD: assert property (!auto_s && !strobe_s |=> $stable(rate_sel))
      else $error("Selection changed with strobe low");
   AST_SEARCH_SET: assert property (carrier_s && (freq_s || hl_s) |=> rate_search_request)
      else $error("Search request missing");
   AST_SEARCH_CLR: assert property (!carrier_s || !(freq_s || hl_s) |=> !rate_search_request)
      else $error("Search request without cause");
   AST_AUTO_DRIVE: assert property (auto_s |=> !rate_index_oe_n
      && {rate_index_bit1_o, rate_index_bit0_o} == rate_sel)
      else $error("Auto index not driven");
   AST_AUTO_HOLD: assert property (auto_s && !rate_search_request |=> $stable(rate_sel))
      else $error("Auto selection moved without search");
   AST_AUTO_STEP: assert property (auto_s && st_q.search && st_q.ars_en
      && st_q.ars_cnt == 32'(ARS_CYCLES - 1) |=> rate_sel == 2'($past(rate_sel) + 2'h1))
      else $error("Auto step missed");
   AST_INDEX_SHOWS_SEL: assert property ({rate_index_bit1_o, rate_index_bit0_o} == rate_sel)
      else $error("Index output differs from selection");
   AST_IRQ_LEVEL: assert property (irq == |(st_q.irq_stat & st_q.irq_mask))
      else $error("Interrupt level wrong");

   COV_MANUAL_LOAD: cover property (!auto_s && strobe_s ##1 $changed(rate_sel));
   COV_AUTO_STEP: cover property (auto_s && rate_search_request ##1 $changed(rate_sel));
   COV_IRQ: cover property ($rose(irq));
   COV_SEARCH_FALL: cover property ($fell(rate_search_request));
   COV_IRQ_CLEAR: cover property ($fell(irq));

   // Event bits follow their causes; the step counter rests outside auto mode
   AST_SEL_EVENT: assert property ($changed(rate_sel) |-> st_q.irq_stat[`RSL_EV_SEL_CHANGE])
      else $error("Selection change not flagged");
   AST_RISE_EVENT: assert property ($rose(rate_search_request) |-> st_q.irq_stat[`RSL_EV_SEARCH_RISE])
      else $error("Search rise not flagged");
   AST_FALL_EVENT: assert property ($fell(rate_search_request) |-> st_q.irq_stat[`RSL_EV_SEARCH_FALL])
      else $error("Search fall not flagged");
   AST_MANUAL_NO_COUNT: assert property (!auto_s |=> st_q.ars_cnt == 32'h0000_0000)
      else $error("Step counter running in manual mode");
   AST_AUTO_OFF: assert property (auto_s && !st_q.ars_en |=> $stable(rate_sel))
      else $error("Auto selection moved while stepping is off");
   AST_BUS_OKAY: assert property (hreadyout && !hresp)
      else $error("Bus answer not ready and OKAY");

endmodule

// ---- rtl/rsl_map.svh ----
// Register offsets, field positions, reset values and timing counts of the rate latch
`ifndef RSL_MAP_SVH
`define RSL_MAP_SVH

`define RSL_OFF_CTRL 6'h00
`define RSL_OFF_STATUS 6'h01
`define RSL_OFF_IRQ_STAT 6'h02
`define RSL_OFF_IRQ_MASK 6'h03

`define RSL_CTRL_ARS_EN 0
`define RSL_CTRL_RST 32'h0000_0001

`define RSL_ST_SEL_LO 0
`define RSL_ST_SEL_HI 1
`define RSL_ST_SEARCH 2
`define RSL_ST_MANUAL 3
`define RSL_ST_STROBE 4

`define RSL_EV_SEL_CHANGE 0
`define RSL_EV_SEARCH_RISE 1
`define RSL_EV_SEARCH_FALL 2
`define RSL_EV_W 3
`define RSL_IRQ_MASK_RST 3'h0

`define RSL_CLK_MHZ 10
`define RSL_ARS_PERIOD_US 1000
`define RSL_ARS_CYCLES (`RSL_ARS_PERIOD_US * `RSL_CLK_MHZ)

`endif

// ---- rtl/rsl_pkg.sv ----
// Types of the rate latch
package rsl_pkg;

   typedef enum logic [1:0] {
      RSL_PH_IDLE = 2'b01,
      RSL_PH_WRITE = 2'b10
   } rsl_phase_t;

   typedef struct packed {
      rsl_phase_t phase;
      logic [5:0] wr_idx;
      logic ars_en;
      logic [1:0] sel;
      logic [31:0] ars_cnt;
      logic search;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic irq;
      logic [1:0] idx_out;
      logic idx_oe_n;
      logic [31:0] hrdata;
      logic hreadyout;
   } rsl_state_t;

endpackage

// ---- rtl/rsl_sync.sv ----
// Three-stage pin synchroniser with agreement filter
module rsl_sync #(
   parameter int W = 1
) (
   input wire logic clock, // System clock
   input wire logic rst_n, // Async reset, active low
   input wire logic clk_en, // Freezes state when low
   input wire logic [W-1:0] din, // Asynchronous pins
   output logic [W-1:0] dout // Filtered level
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] out;
   } rsl_sync_state_t;

   rsl_sync_state_t st_q;
   rsl_sync_state_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.s1 = din;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int i = 0; i < W; i++) begin
         if (st_q.s2[i] == st_q.s3[i]) begin
            st_d.out[i] = st_q.s2[i];
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else if (clk_en) begin
         st_q <= st_d;
      end
   end

   assign dout = st_q.out;

endmodule

// ---- dv/rsl_ctrl_model.sv ----
// Controller model that drives the strobe and shares the index bus
module rsl_ctrl_model (
   input wire logic [1:0] want, // Index pattern to present
   input wire logic wr, // Strobe level to present
   input wire logic [1:0] dev_idx, // Device index drive values
   input wire logic dev_oe_n, // Device drive enable, low drives
   output logic strobe, // Write strobe pin
   output logic [1:0] bus // Resolved index bus level
);
   timeunit 1ns;
   timeprecision 1ns;
   assign strobe = wr;
   // Controller lets go of the bus while the device drives it
   assign bus = dev_oe_n ? want : dev_idx;
endmodule

// ---- dv/tb.sv ----
// Self-checking bench of the rate latch
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, auto_sel = 1'b0, wr = 1'b0;
   logic carrier = 1'b0, freq_det = 1'b0, hl = 1'b0, ce = 1'b1;
   logic [1:0] htrans = 2'h0, want = 2'h0, bus, idx_o, sel;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic hreadyout, hresp, oe_n, strobe, search, irq;
   int fails = 0, n_tests = 0, e, i;
   int exp_q[$];
   always #50 clock = ~clock;
   rsl_top #(.ARS_CYCLES(8)) u_dut (.clock(clock), .rst_n(rst_n), .clk_en(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .auto_select(auto_sel), .rate_write_strobe(strobe),
      .rate_index_bit0_i(bus[0]), .rate_index_bit1_i(bus[1]), .rate_index_bit0_o(idx_o[0]),
      .rate_index_bit1_o(idx_o[1]), .rate_index_oe_n(oe_n), .carrier_detect_flag(carrier),
      .frequency_detector(freq_det), .harmonic_lock_flag(hl), .rate_search_request(search), .rate_sel(sel),
      .irq(irq));
   rsl_ctrl_model u_ctrl (.want(want), .wr(wr), .dev_idx(idx_o), .dev_oe_n(oe_n), .strobe(strobe), .bus(bus));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wait_rdy();
      int k;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (hreadyout !== 1'b1 && k < 20);
      if (k >= 20) begin
         fails++;
         report_and_stop();
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      wait_rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
   endtask
   // Search request as the rules state it
   function automatic int model_search(input int c, input int f, input int h);
      return c & (f | h);
   endfunction
   task automatic settle();
      repeat (7) @(posedge clock);
      @(negedge clock);
   endtask
   // Waits for a new selection; a stuck counter ends the run
   task automatic wait_sel(input int prev);
      int k;
      k = 0;
      do begin
         @(negedge clock);
         k++;
      end while (sel === 2'(prev) && k < 40);
      if (k >= 40) begin
         fails++;
         report_and_stop();
      end
   endtask
   initial begin
      e = $urandom(32'h7C425198);
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      @(negedge clock);
      chk("oe_n", 1, oe_n);
      chk("sel", 0, sel);
      ahb(1'b1, 32'hC, 32'h7, rd);
      ahb(1'b0, 32'hC, 32'h0, rd);
      chk("mask", 7, rd);
      ahb(1'b0, 32'h40, 32'h0, rd);
      chk("unmapped", 0, rd);
      for (i = 0; i < 4; i++) begin
         @(posedge clock);
         wr <= 1'b1;
         want <= 2'(3 - i);
         settle();
         chk("sel", 32'(3 - i), sel);
         chk("idx", 32'(3 - i), idx_o);
         chk("oe_n", 1, oe_n);
      end
      chk("irq", 1, irq);
      ahb(1'b0, 32'h8, 32'h0, rd);
      chk("irq_stat", 1, rd);
      chk("irq", 0, irq);
      @(posedge clock);
      wr <= 1'b0;
      settle();
      for (i = 0; i < 4; i++) begin
         @(posedge clock);
         want <= 2'($urandom);
         settle();
         chk("held sel", 0, sel);
      end
      for (i = 0; i < 8; i++) begin
         @(posedge clock);
         {carrier, freq_det, hl} <= 3'(i);
         settle();
         chk("search", model_search(i[2], i[1], i[0]), search);
      end
      ahb(1'b0, 32'h8, 32'h0, rd);
      chk("irq_stat", 2, rd);
      @(posedge clock);
      auto_sel <= 1'b1;
      e = 0;
      for (i = 1; i <= 5; i++) exp_q.push_back((e + i) % 4);
      while (exp_q.size() > 0) begin
         wait_sel(e);
         e = exp_q.pop_front();
         chk("auto sel", 32'(e), sel);
         chk("bus", 32'(e), bus);
         chk("oe_n", 0, oe_n);
      end
      @(posedge clock);
      freq_det <= 1'b0;
      hl <= 1'b0;
      repeat (30) @(posedge clock);
      @(negedge clock);
      chk("stopped sel", 32'(e), sel);
      ahb(1'b0, 32'h4, 32'h0, rd);
      chk("status", 32'(e), rd);
      chk("hresp", 0, hresp);
      chk("irq", 1, irq);
      ahb(1'b0, 32'h8, 32'h0, rd);
      chk("irq_stat", 5, rd);
      // Clock enable low freezes the synchroniser and the selection
      @(posedge clock);
      ce <= 1'b0;
      freq_det <= 1'b1;
      repeat (30) @(posedge clock);
      @(negedge clock);
      chk("frozen sel", 32'(e), sel);
      chk("frozen search", 0, search);
      @(posedge clock);
      ce <= 1'b1;
      wait_sel(e);
      e = (e + 1) % 4;
      chk("resumed sel", 32'(e), sel);
      ahb(1'b1, 32'h0, 32'h0, rd);
      repeat (30) @(posedge clock);
      @(negedge clock);
      chk("stepping off sel", 32'(e), sel);
      ahb(1'b0, 32'h0, 32'h0, rd);
      chk("ctrl", 0, rd);
      report_and_stop();
   end
endmodule
